// ### src/acc_pkg.sv
// constants, field layout and types of the converter control block
// assumes a single 10 MHz core clock and an 8-bit register port
// Overview of operation
// - reference code: external, supply, reserved, internal
// - selection changes wait until conversion completes
// - justify bit picks left or right layout
// - justify change reaches result layout at once
// - channel codes: inputs 0-7, bandgap, ground
// - differential codes with gain 10x/200x or 1x
// - offset codes tie input 0 or input 2 to both
// - enable bit switches converter on and off
// - clearing enable aborts running conversion
// - each start write with enable set, while idle, gives one conversion
// - free running: one start, then continuous
// - first conversion 25 ticks, later ones 13
// - start reads one while converting, then zero
// - writing zero to start does nothing
// - registers answer at offset and offset+0x20
// - done flag set at end, cleared by ack/one
// - converter clock divides by 2 up to 128
// - auto trigger starts on trigger rising edge
package acc_pkg;

    // register offsets in the i/o space
    localparam logic [7:0] OFS_CTRL        = 8'h06;
    localparam logic [7:0] OFS_MUX         = 8'h07;
    localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;

    // control register fields
    localparam int         CTRL_EN_BIT    = 7;
    localparam int         CTRL_START_BIT = 6;
    localparam int         CTRL_ATE_BIT   = 5;
    localparam int         CTRL_FLAG_BIT  = 4;
    localparam int         CTRL_IE_BIT    = 3;
    localparam int         CTRL_PS_MSB    = 2;
    localparam int         CTRL_PS_LSB    = 0;
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // multiplexer register fields
    localparam int         MUX_REF_MSB   = 7;
    localparam int         MUX_REF_LSB   = 6;
    localparam int         MUX_LJ_BIT    = 5;
    localparam int         MUX_CHAN_MSB  = 4;
    localparam int         MUX_CHAN_LSB  = 0;
    localparam logic [7:0] MUX_RESET     = 8'h00;

    // reference codes
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_AVCC     = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;

    // channel code boundaries
    localparam logic [4:0] CHAN_SE_LAST   = 5'h07;
    localparam logic [4:0] CHAN_GAIN_LAST = 5'h0F;
    localparam logic [4:0] CHAN_NEG1_LAST = 5'h17;
    localparam logic [4:0] CHAN_BANDGAP   = 5'h1E;
    localparam logic [4:0] CHAN_GROUND    = 5'h1F;

    // conversion lengths in converter clock ticks
    localparam int         FIRST_CONV_CYCLES  = 25;
    localparam int         NORMAL_CONV_CYCLES = 13;
    localparam logic [4:0] FIRST_LAST         = 5'(FIRST_CONV_CYCLES - 1);
    localparam logic [4:0] NORMAL_LAST        = 5'(NORMAL_CONV_CYCLES - 1);

    // prescaler codes
    localparam logic [2:0] PS_MIN_CODE = 3'h1;

    typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} acc_gain_t;
    typedef enum {S_IDLE, S_CONV} acc_state_t;

endpackage

// ### src/acc_prescaler.sv
// converter clock divider: one-cycle tick every 2 to 128 core cycles
// assumes run is low whenever the converter is off
`timescale 1ns/1ns
`default_nettype none
module acc_prescaler (
    // system
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] code,
    // converter clock enable
    output logic            tick_o
);

    logic [6:0] cnt_r;
    logic [6:0] top;

    // codes 0 and 1 both divide by two
    assign top = (code <= acc_pkg::PS_MIN_CODE) ? 7'h01
                 : 7'((8'h01 << code) - 8'h01);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r  <= 7'h00;
            tick_o <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r  <= 7'h00;
            tick_o <= 1'b0;
        end
        else if (cnt_r >= top)
        begin
            cnt_r  <= 7'h00;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_r  <= cnt_r + 7'h01;
            tick_o <= 1'b0;
        end
    end

    a_div_by_two: assert property (@(posedge clk) disable iff (rst)
        (tick_o && run && code == 3'h0) ##1 (run && code == 3'h0) |-> !tick_o ##1 tick_o)
        else $error("divide by two period wrong");

    a_div_by_128: assert property (@(posedge clk) disable iff (rst)
        tick_o && run && code == 3'h7 |=> !tick_o [*8])
        else $error("divide by 128 ticks too early");

endmodule
`default_nettype wire

// ### src/acc_rise.sv
// rising edge detector for the selected trigger level
// assumes the level is synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module acc_rise (
    // system
    input  wire logic clk,
    input  wire logic rst,
    // level in, pulse out
    input  wire logic level_i,
    output logic      rise_o
);

    logic prev_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_r <= 1'b0;
        else
            prev_r <= level_i;
    end

    assign rise_o = level_i && !prev_r;

    a_rise_edge: assert property (@(posedge clk) disable iff (rst)
        rise_o |-> level_i && !$past(level_i))
        else $error("trigger edge without low to high step");

endmodule
`default_nettype wire

// ### src/acc_top.sv
// converter channel and conversion control with its two registers
// assumes a synchronous 8-bit register port and a front end that
// presents its 10-bit result on sar_result when the conversion ends
`timescale 1ns/1ns
`default_nettype none
module acc_top (
    // system
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        io_addr,
    input  wire logic              io_we,
    input  wire logic              io_re,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    // interrupt controller side
    input  wire logic              irq_ack,
    output logic                   irq_req,
    // trigger
    input  wire logic              trigger_level,
    input  wire logic              free_running,
    // analog front end
    input  wire logic [9:0]        sar_result,
    output logic                   converter_on,
    output logic                   conv_clk_en,
    output logic                   conv_busy,
    output logic                   conv_init,
    output logic                   ref_external,
    output logic                   ref_avcc,
    output logic                   ref_internal,
    output logic                   single_ended,
    output logic                   bandgap_sel,
    output logic                   ground_sel,
    output logic      [2:0]        pos_input,
    output logic      [2:0]        neg_input,
    output acc_pkg::acc_gain_t     gain_sel,
    // result layout
    output logic      [7:0]        result_low,
    output logic      [7:0]        result_high
);

    acc_pkg::acc_state_t state_r;
    acc_pkg::acc_state_t state_nxt;
    logic       en_r;
    logic       start_r;
    logic       ate_r;
    logic       flag_r;
    logic       ie_r;
    logic [2:0] ps_r;
    logic [7:0] mux_r;
    logic [1:0] ref_app_r;
    logic [4:0] chan_app_r;
    logic [4:0] cnt_r;
    logic       first_r;
    logic       first_used_r;
    logic [9:0] raw_r;
    logic       tick;
    logic       rise;
    logic       hit_ctrl;
    logic       hit_mux;
    logic       ctrl_we;
    logic       en_nxt;
    logic       sw_start;
    logic       trig_start;
    logic       done;
    logic       restart;
    logic       start_now;
    logic [4:0] last;
    logic [7:0] ctrl_rd;

    acc_prescaler u_prescaler (
        .clk    (clk),
        .rst    (rst),
        .run    (en_r),
        .code   (ps_r),
        .tick_o (tick)
    );

    acc_rise u_rise (
        .clk     (clk),
        .rst     (rst),
        .level_i (trigger_level),
        .rise_o  (rise)
    );

    // both the i/o offset and its data-space alias decode
    assign hit_ctrl = (io_addr == acc_pkg::OFS_CTRL)
                   || (io_addr == 8'(acc_pkg::OFS_CTRL + acc_pkg::DATA_SPACE_BIAS));
    assign hit_mux  = (io_addr == acc_pkg::OFS_MUX)
                   || (io_addr == 8'(acc_pkg::OFS_MUX + acc_pkg::DATA_SPACE_BIAS));
    assign ctrl_we  = io_we && hit_ctrl;

    // a start written together with enable is honoured
    assign en_nxt     = ctrl_we ? io_wdata[acc_pkg::CTRL_EN_BIT] : en_r;
    assign sw_start   = ctrl_we && io_wdata[acc_pkg::CTRL_START_BIT];
    assign trig_start = ate_r && rise && en_r;
    assign last       = first_used_r ? acc_pkg::FIRST_LAST : acc_pkg::NORMAL_LAST;
    assign done       = (state_r == acc_pkg::S_CONV) && tick && (cnt_r == last) && en_nxt;
    assign restart    = ate_r && free_running;
    assign start_now  = ((state_r == acc_pkg::S_IDLE) && en_nxt && (sw_start || trig_start))
                     || (done && restart);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            acc_pkg::S_IDLE:
                if (en_nxt && (sw_start || trig_start))
                    state_nxt = acc_pkg::S_CONV;
            acc_pkg::S_CONV:
                if (!en_nxt)
                    state_nxt = acc_pkg::S_IDLE;
                else if (done && !restart)
                    state_nxt = acc_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r   <= acc_pkg::S_IDLE;
            conv_busy <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            conv_busy <= (state_nxt == acc_pkg::S_CONV);
        end
    end

    // tick count within the running conversion
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 5'h00;
        else if (start_now)
            cnt_r <= 5'h00;
        else if ((state_r == acc_pkg::S_CONV) && tick)
            cnt_r <= cnt_r + 5'h01;
    end

    // the long conversion follows every off period of the converter except a single cycle ended by an enable and start write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            first_r      <= 1'b1;
            first_used_r <= 1'b1;
        end
        else
        begin
            if (!en_r)
                first_r <= 1'b1;
            else if (done)
                first_r <= 1'b0;
            if (start_now)
                first_used_r <= first_r && !done;
        end
    end

    // control register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_r  <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_EN_BIT];
            ate_r <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_ATE_BIT];
            ie_r  <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_IE_BIT];
            ps_r  <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_PS_MSB:acc_pkg::CTRL_PS_LSB];
        end
        else if (ctrl_we)
        begin
            en_r  <= io_wdata[acc_pkg::CTRL_EN_BIT];
            ate_r <= io_wdata[acc_pkg::CTRL_ATE_BIT];
            ie_r  <= io_wdata[acc_pkg::CTRL_IE_BIT];
            ps_r  <= io_wdata[acc_pkg::CTRL_PS_MSB:acc_pkg::CTRL_PS_LSB];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            start_r <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_START_BIT];
        else if (start_now)
            start_r <= 1'b1;
        else if (!en_nxt || done)
            start_r <= 1'b0;
    end

    // a completion in the clearing cycle keeps the flag set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_r <= acc_pkg::CTRL_RESET[acc_pkg::CTRL_FLAG_BIT];
        else if (done)
            flag_r <= 1'b1;
        else if ((ctrl_we && io_wdata[acc_pkg::CTRL_FLAG_BIT]) || irq_ack)
            flag_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_req <= 1'b0;
        else
            irq_req <= flag_r && ie_r;
    end

    // multiplexer register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mux_r <= acc_pkg::MUX_RESET;
        else if (io_we && hit_mux)
            mux_r <= io_wdata;
    end

    // applied selection frozen while converting; reserved reference keeps the old one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_app_r  <= acc_pkg::MUX_RESET[acc_pkg::MUX_REF_MSB:acc_pkg::MUX_REF_LSB];
            chan_app_r <= acc_pkg::MUX_RESET[acc_pkg::MUX_CHAN_MSB:acc_pkg::MUX_CHAN_LSB];
        end
        else if ((state_r != acc_pkg::S_CONV) || done)
        begin
            // free running restarts in the done cycle, so the next conversion must see it
            chan_app_r <= mux_r[acc_pkg::MUX_CHAN_MSB:acc_pkg::MUX_CHAN_LSB];
            if (mux_r[acc_pkg::MUX_REF_MSB:acc_pkg::MUX_REF_LSB] != acc_pkg::REF_RESERVED)
                ref_app_r <= mux_r[acc_pkg::MUX_REF_MSB:acc_pkg::MUX_REF_LSB];
        end
    end

    // decoded selection to the front end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_external <= 1'b1;
            ref_avcc     <= 1'b0;
            ref_internal <= 1'b0;
            single_ended <= 1'b1;
            bandgap_sel  <= 1'b0;
            ground_sel   <= 1'b0;
            pos_input    <= 3'h0;
            neg_input    <= 3'h0;
            gain_sel     <= acc_pkg::GAIN_1X;
        end
        else
        begin
            ref_external <= (ref_app_r == acc_pkg::REF_EXTERNAL);
            ref_avcc     <= (ref_app_r == acc_pkg::REF_AVCC);
            ref_internal <= (ref_app_r == acc_pkg::REF_INTERNAL);
            bandgap_sel  <= (chan_app_r == acc_pkg::CHAN_BANDGAP);
            ground_sel   <= (chan_app_r == acc_pkg::CHAN_GROUND);
            if (chan_app_r <= acc_pkg::CHAN_SE_LAST || chan_app_r >= acc_pkg::CHAN_BANDGAP)
            begin
                single_ended <= 1'b1;
                pos_input    <= chan_app_r[2:0];
                neg_input    <= 3'h0;
                gain_sel     <= acc_pkg::GAIN_1X;
            end
            else if (chan_app_r <= acc_pkg::CHAN_GAIN_LAST)
            begin
                // offset codes fall out of this as input 0 or input 2 on both sides
                single_ended <= 1'b0;
                pos_input    <= {1'b0, chan_app_r[2], chan_app_r[0]};
                neg_input    <= chan_app_r[2] ? 3'h2 : 3'h0;
                gain_sel     <= chan_app_r[1] ? acc_pkg::GAIN_200X : acc_pkg::GAIN_10X;
            end
            else
            begin
                single_ended <= 1'b0;
                pos_input    <= chan_app_r[2:0];
                neg_input    <= (chan_app_r <= acc_pkg::CHAN_NEG1_LAST) ? 3'h1 : 3'h2;
                gain_sel     <= acc_pkg::GAIN_1X;
            end
        end
    end

    // result capture and layout; layout follows the justify bit every cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            raw_r <= 10'h000;
        else if (done)
            raw_r <= sar_result;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            result_low  <= 8'h00;
            result_high <= 8'h00;
        end
        else if (mux_r[acc_pkg::MUX_LJ_BIT])
        begin
            result_low  <= {raw_r[1:0], 6'h00};
            result_high <= raw_r[9:2];
        end
        else
        begin
            result_low  <= raw_r[7:0];
            result_high <= {6'h00, raw_r[9:8]};
        end
    end

    // front end status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            converter_on <= 1'b0;
            conv_clk_en  <= 1'b0;
            conv_init    <= 1'b0;
        end
        else
        begin
            converter_on <= en_r;
            conv_clk_en  <= tick;
            conv_init    <= (state_r == acc_pkg::S_CONV) && first_used_r;
        end
    end

    // read data registered; unmapped addresses read zero
    assign ctrl_rd = {en_r, start_r, ate_r, flag_r, ie_r, ps_r};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            io_rdata <= 8'h00;
        else if (io_re && hit_ctrl)
            io_rdata <= ctrl_rd;
        else if (io_re && hit_mux)
            io_rdata <= mux_r;
        else
            io_rdata <= 8'h00;
    end

    // helper: ticks seen in the current conversion
    logic [5:0] chk_ticks_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            chk_ticks_r <= 6'h00;
        else if ((state_r != acc_pkg::S_CONV) || done)
            chk_ticks_r <= 6'h00;
        else if (tick)
            chk_ticks_r <= chk_ticks_r + 6'h01;
    end

    a_ref_internal: assert property (@(posedge clk) disable iff (rst)
        ref_app_r == 2'h3 |=> ref_internal && !ref_avcc && !ref_external)
        else $error("internal reference not decoded");

    a_sel_frozen: assert property (@(posedge clk) disable iff (rst)
        state_r == acc_pkg::S_CONV && !done |=> $stable(chan_app_r) && $stable(ref_app_r))
        else $error("selection changed during conversion");

    a_justify_now: assert property (@(posedge clk) disable iff (rst)
        mux_r[5] |=> result_high == $past(raw_r[9:2]) && result_low[5:0] == 6'h00)
        else $error("left layout not applied next cycle");

    a_bandgap_code: assert property (@(posedge clk) disable iff (rst)
        chan_app_r == 5'h1E |=> bandgap_sel && single_ended && !ground_sel)
        else $error("bandgap code not decoded");

    a_offset_code: assert property (@(posedge clk) disable iff (rst)
        chan_app_r == 5'h0A |=> pos_input == 3'h0 && neg_input == 3'h0
                               && gain_sel == acc_pkg::GAIN_200X && !single_ended)
        else $error("offset code at 200x wrong");

    a_neg_one: assert property (@(posedge clk) disable iff (rst)
        chan_app_r == 5'h13 |=> pos_input == 3'h3 && neg_input == 3'h1
                               && gain_sel == acc_pkg::GAIN_1X)
        else $error("1x pair with input 1 negative wrong");

    a_on_follows: assert property (@(posedge clk) disable iff (rst)
        ctrl_we |-> ##2 converter_on == $past(io_wdata[7], 2))
        else $error("converter on does not follow enable");

    a_abort: assert property (@(posedge clk) disable iff (rst)
        state_r == acc_pkg::S_CONV && ctrl_we && !io_wdata[7] |=> !conv_busy && !start_r)
        else $error("disable did not abort conversion");

    a_sw_start: assert property (@(posedge clk) disable iff (rst)
        state_r == acc_pkg::S_IDLE && ctrl_we && io_wdata[7:6] == 2'h3 |=> conv_busy && start_r)
        else $error("start write did not start conversion");

    a_free_run: assert property (@(posedge clk) disable iff (rst)
        done && ate_r && free_running |=> conv_busy && start_r && cnt_r == 5'h00)
        else $error("free running did not continue");

    a_conv_len: assert property (@(posedge clk) disable iff (rst)
        done |-> chk_ticks_r == (first_used_r ? 6'h18 : 6'h0C))
        else $error("conversion length wrong");

    a_start_reads: assert property (@(posedge clk) disable iff (rst)
        io_re && hit_ctrl && state_r == acc_pkg::S_CONV |=> io_rdata[6])
        else $error("start bit read low while converting");

    a_zero_start: assert property (@(posedge clk) disable iff (rst)
        state_r == acc_pkg::S_IDLE && ctrl_we && !io_wdata[6] && !ate_r |=> !conv_busy)
        else $error("zero start write began a conversion");

    a_alias_read: assert property (@(posedge clk) disable iff (rst)
        io_re && io_addr == 8'h27 |=> io_rdata == $past(mux_r))
        else $error("data-space alias read wrong");

    a_flag_set: assert property (@(posedge clk) disable iff (rst)
        done |=> flag_r && raw_r == $past(sar_result))
        else $error("done flag or result not set");

    a_auto_start: assert property (@(posedge clk) disable iff (rst)
        state_r == acc_pkg::S_IDLE && ate_r && en_r && rise && !(ctrl_we && !io_wdata[7])
        |=> conv_busy)
        else $error("trigger edge did not start conversion");

endmodule
`default_nettype wire

// ### tb/tb_acc_top.sv
// self-checking bench for the converter control block
// drives register port, trigger and front end result directly
`timescale 1ns/1ns
`default_nettype none
module tb_acc_top;
    logic               clk, rst, io_we, io_re, irq_ack, trigger_level, free_running;
    logic [7:0]         io_addr, io_wdata, io_rdata, result_low, result_high, d;
    logic [9:0]         sar_result;
    logic               irq_req, converter_on, conv_clk_en, conv_busy, conv_init;
    logic               ref_external, ref_avcc, ref_internal, single_ended;
    logic               bandgap_sel, ground_sel;
    logic [2:0]         pos_input, neg_input;
    acc_pkg::acc_gain_t gain_sel;
    logic [31:0]        seed = 32'h0B50AA76;
    logic [31:0]        r;
    logic [10:0]        m, g;
    int                 n_errors = 0;
    int                 n_tests = 0;
    int                 c;
    int                 k;

    acc_top uut (.*);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // {single, bandgap, ground, pos, neg, gain}
    function automatic logic [10:0] dec(input logic [4:0] k);
        if (k <= 5'h07)
            return {3'b100, k[2:0], 5'h00};
        if (k <= 5'h0F)
            return {4'b0000, k[2], k[0], 1'b0, k[2], 1'b0, k[1] ? 2'h2 : 2'h1};
        if (k <= 5'h1D)
            return {3'b000, k[2:0], k[3] ? 3'h2 : 3'h1, 2'h0};
        return (k == 5'h1E) ? 11'h600 : 11'h500;
    endfunction

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= v;
        io_we    <= 1'b1;
        @(posedge clk);
        io_we    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        io_addr <= a;
        io_re   <= 1'b1;
        @(posedge clk);
        io_re   <= 1'b0;
        @(negedge clk);
        chk("io_rdata", {8'h00, io_rdata}, {8'h00, e});
    endtask

    // bounded wait for the end of a conversion
    task automatic wait_idle(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (conv_busy === 1'b1 && n < 4000);
        if (n >= 4000)
        begin
            n_errors++;
            end_sim();
        end
    endtask

    // first tick lands anywhere within one divider period
    task automatic conv(input logic [7:0] ctl, input int ticks, input int div);
        int n;
        wr(8'h06, ctl);
        rd(8'h26, ctl);
        chk("init", conv_init, {15'h0, ticks == 25});
        wait_idle(n);
        chk("conv_len", {15'h0, n >= (ticks - 1) * div - 2 && n <= ticks * div + 3}, 16'h1);
        rd(8'h06, (ctl & 8'hBF) | 8'h10);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        rst           = 1'b1;
        io_we         = 1'b0;
        io_re         = 1'b0;
        io_addr       = 8'h00;
        io_wdata      = 8'h00;
        irq_ack       = 1'b0;
        trigger_level = 1'b0;
        free_running  = 1'b0;
        r             = rnd();
        sar_result    = r[9:0];
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(8'h06, acc_pkg::CTRL_RESET);
        rd(8'h07, acc_pkg::MUX_RESET);
        chk("ref_ext", ref_external, 16'h1);
        for (c = 0; c < 8; c++)
        begin
            r = rnd();
            d = r[7:0];
            if (d[7:6] == 2'h2)
                d[6] = 1'b1;
            wr(r[8] ? 8'h07 : 8'h27, d);
            rd(r[8] ? 8'h27 : 8'h07, d);
        end
        rd(8'h16, 8'h00);
        // reserved code 2 keeps the supply reference of code 1
        for (c = 0; c < 4; c++)
        begin
            wr(8'h07, {c[1:0], 6'h00});
            // applied selection, then its decode: two edges after the register
            repeat (3) @(negedge clk);
            chk("ref", {ref_internal, ref_avcc, ref_external}, c == 0 ? 1 : c == 3 ? 4 : 2);
        end
        for (c = 0; c < 32; c++)
        begin
            wr(8'h07, {3'h0, c[4:0]});
            repeat (3) @(negedge clk);
            m = (c >= 30) ? 11'h700 : (c < 8) ? 11'h7FC : 11'h7FF;
            g = {single_ended, bandgap_sel, ground_sel, pos_input, neg_input, gain_sel};
            chk("chan", g & m, dec(c[4:0]) & m);
        end
        wr(8'h07, 8'h00);
        conv(8'hC0, 25, 2);
        chk("on", converter_on, 16'h1);
        chk("res", {result_high, result_low}, {6'h00, sar_result});
        wr(8'h07, 8'h20);
        repeat (2) @(negedge clk);
        chk("res_lj", {result_high, result_low}, {sar_result, 6'h00});
        wr(8'h06, 8'h90);
        rd(8'h06, 8'h80);
        conv(8'hCF, 13, 128);
        chk("irq", irq_req, 16'h1);
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        rd(8'h06, 8'h8F);
        chk("irq", irq_req, 16'h0);
        wr(8'h06, 8'hC0);
        wr(8'h07, 8'h1F);
        wr(8'h06, 8'h80);
        repeat (2) @(negedge clk);
        chk("busy", conv_busy, 16'h1);
        chk("gnd", ground_sel, 16'h0);
        wait_idle(c);
        repeat (2) @(negedge clk);
        chk("gnd", ground_sel, 16'h1);
        wr(8'h06, 8'hD0);
        wr(8'h06, 8'h00);
        repeat (2) @(negedge clk);
        chk("abort", {converter_on, conv_busy}, 16'h0);
        rd(8'h06, 8'h00);
        wr(8'h06, 8'hA0);
        trigger_level <= 1'b1;
        repeat (4) @(negedge clk);
        chk("trig", conv_busy, 16'h1);
        wait_idle(c);
        @(posedge clk);
        trigger_level <= 1'b0;
        free_running  <= 1'b1;
        wr(8'h06, 8'hE0);
        c = 0;
        k = 0;
        repeat (120)
        begin
            @(negedge clk);
            if (conv_busy !== 1'b1)
                c++;
            if (conv_clk_en === 1'b1)
                k++;
        end
        chk("free", c[15:0], 16'h0);
        chk("clk_en", k[15:0], 16'h003C);
        rd(8'h06, 8'hF0);
        wr(8'h06, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
